// ===== src/soc_slow_osc.sv
// slow oscillator control: apb registers, start-up mask, pins, outputs, interrupt
`timescale 1ns/1ps
`default_nettype none
// How it works
// - after power-on the oscillator is off and pins stay with general io
// - while enabled in a crystal mode the clock unit owns both selected oscillator pins
// - external-clock mode uses only the input pin; output pin is released
// - mode field picks external clock or crystal operation
// - sleep modes never gate or disable a running oscillator
// - oscillator output stays masked for the selected start-up length
// - start-up delay applies after hard reset and every restart
// - ready flag sets once oscillator is stable
// - ready rising raises an interrupt when its mask bit is set
// - writing one to the enable register sets the ready mask bit
// - only power-on reset returns oscillator and its control to default
// - 1 kHz output runs only while its enable bit is one
// - 32 kHz output gated by own enable, set by power-on reset
// - pin-select bit routes the oscillator to one of two pin sets
// - mode 0 external, 1 crystal, 4 crystal high current, others reserved
// - pin-select zero uses default pins, one uses alternate pins
module soc_slow_osc (
   input wire logic CLK_IN, // system clock, 100 MHz
   input wire logic RESET_N_IN, // power-on reset, async, active low
   input wire logic SYS_RESET_N_IN, // any other reset, sync, active low
   input wire logic PSEL_IN, // apb select
   input wire logic PENABLE_IN, // apb enable
   input wire logic PWRITE_IN, // apb write
   input wire logic [7:0] PADDR_IN, // apb byte address
   input wire logic [31:0] PWDATA_IN, // apb write data
   output logic [31:0] PRDATA_OUT, // apb read data
   output logic PREADY_OUT, // apb ready
   output logic PSLVERR_OUT, // apb error, unmapped address
   input wire logic SLOW_XTAL_IN_IN, // default oscillator input pin level
   input wire logic ALT_XTAL_IN_IN, // alternate oscillator input pin level
   output logic SLOW_XTAL_IN_OWN_OUT, // clock unit owns default input pin
   output logic SLOW_XTAL_OUT_OWN_OUT, // clock unit owns default output pin
   output logic ALT_XTAL_IN_OWN_OUT, // clock unit owns alternate input pin
   output logic ALT_XTAL_OUT_OWN_OUT, // clock unit owns alternate output pin
   output logic OSC_ENABLE_OUT, // oscillator core enable
   output logic OSC_XTAL_MODE_OUT, // crystal amplifier on
   output logic OSC_HIGH_CURRENT_OUT, // crystal high current drive
   output logic CLK32K_OUT, // masked 32 kHz clock
   output logic CLK1K_OUT, // masked 1 kHz clock
   output logic IRQ_OUT // interrupt request, level
);
   import soc_pkg::*;

   // slow_osc_control fields
   logic osc_en;
   logic khz1_en;
   logic khz32_en;
   logic pin_alt;
   logic [SOC_MODE_W-1:0] mode;
   logic [SOC_STARTUP_W-1:0] startup;
   soc_state_e state;
   soc_state_e next_state;
   logic cnt_done;
   logic osc_pin;
   logic osc_q;
   logic osc_edge;
   logic [3:0] div_cnt;
   logic khz1_div;
   logic rdy_q;
   logic rdy_rise;
   logic int_status;
   logic int_mask;
   logic wr_fire;
   logic rd_phase;
   logic [31:0] next_prdata;
   logic next_slverr;
   logic [SOC_MODE_W-1:0] wr_mode;
   logic mode_legal;
   logic ready;

   assign wr_fire = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN;
   assign rd_phase = PSEL_IN && PENABLE_IN && !PREADY_OUT;
   assign wr_mode = PWDATA_IN[SOC_MODE_LSB +: SOC_MODE_W];
   assign mode_legal = (wr_mode == SOC_MODE_EXT) || (wr_mode == SOC_MODE_XTAL)
      || (wr_mode == SOC_MODE_XTAL_HC);
   assign ready = (state == SOC_READY);

   // control register: only power-on reset loads its reset value
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         osc_en <= SOC_CTRL_RESET[SOC_EN_BIT];
         khz1_en <= SOC_CTRL_RESET[SOC_KHZ1_BIT];
         khz32_en <= SOC_CTRL_RESET[SOC_KHZ32_BIT];
         pin_alt <= SOC_CTRL_RESET[SOC_ALTERNATE_PIN_SELECT_BIT];
         mode <= SOC_MODE_RESET;
         startup <= SOC_STARTUP_RESET;
      end else if (wr_fire && PADDR_IN == SOC_CTRL_ADDR) begin
         // system resets do not reach here
         osc_en <= PWDATA_IN[SOC_EN_BIT];
         khz1_en <= PWDATA_IN[SOC_KHZ1_BIT];
         khz32_en <= PWDATA_IN[SOC_KHZ32_BIT];
         pin_alt <= PWDATA_IN[SOC_ALTERNATE_PIN_SELECT_BIT];
         startup <= PWDATA_IN[SOC_STARTUP_LSB +: SOC_STARTUP_W];
         // reserved mode codes leave the field unchanged
         if (mode_legal) begin
            mode <= wr_mode;
         end
      end
   end

   // oscillator cycle detection on the selected pin
   assign osc_pin = pin_alt ? ALT_XTAL_IN_IN : SLOW_XTAL_IN_IN;
   assign osc_edge = osc_en && osc_pin && !osc_q;

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         osc_q <= 1'b0;
      end else begin
         osc_q <= osc_en && osc_pin;
      end
   end

   soc_startup_cnt u_startup (
      .clk_in(CLK_IN),
      .rst_n_in(RESET_N_IN),
      .load_in(state != SOC_STARTING),
      .edge_in(osc_edge),
      .sel_in(startup),
      .done_out(cnt_done)
   );

   // oscillator state: sleep has no input here, so nothing stops it but osc_en
   always_comb begin
      next_state = state;
      case (state)
         SOC_OFF: begin
            if (osc_en) begin
               next_state = SOC_STARTING;
            end
         end
         SOC_STARTING: begin
            if (!osc_en) begin
               next_state = SOC_OFF;
            end else if (cnt_done) begin
               next_state = SOC_READY;
            end
         end
         SOC_READY: begin
            if (!osc_en) begin
               next_state = SOC_OFF;
            end
         end
         default: begin
            next_state = SOC_OFF;
         end
      endcase
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state <= SOC_OFF;
      end else begin
         state <= next_state;
      end
   end

   // 1 kHz divider, held in reset while masked
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         div_cnt <= SOC_KHZ1_CLR;
         khz1_div <= 1'b0;
      end else if (!ready) begin
         div_cnt <= SOC_KHZ1_CLR;
         khz1_div <= 1'b0;
      end else if (osc_edge) begin
         div_cnt <= div_cnt + SOC_KHZ1_ONE;
         if (div_cnt == SOC_KHZ1_LAST) begin
            khz1_div <= !khz1_div;
         end
      end
   end

   // clock outputs and pin ownership
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         CLK32K_OUT <= 1'b0;
         CLK1K_OUT <= 1'b0;
      end else begin
         CLK32K_OUT <= ready && khz32_en && osc_pin;
         CLK1K_OUT <= ready && khz1_en && khz1_div;
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         SLOW_XTAL_IN_OWN_OUT <= 1'b0;
         SLOW_XTAL_OUT_OWN_OUT <= 1'b0;
         ALT_XTAL_IN_OWN_OUT <= 1'b0;
         ALT_XTAL_OUT_OWN_OUT <= 1'b0;
      end else begin
         SLOW_XTAL_IN_OWN_OUT <= osc_en && !pin_alt;
         SLOW_XTAL_OUT_OWN_OUT <= osc_en && !pin_alt && (mode != SOC_MODE_EXT);
         ALT_XTAL_IN_OWN_OUT <= osc_en && pin_alt;
         ALT_XTAL_OUT_OWN_OUT <= osc_en && pin_alt && (mode != SOC_MODE_EXT);
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         OSC_ENABLE_OUT <= 1'b0;
         OSC_XTAL_MODE_OUT <= 1'b0;
         OSC_HIGH_CURRENT_OUT <= 1'b0;
      end else begin
         OSC_ENABLE_OUT <= osc_en;
         OSC_XTAL_MODE_OUT <= osc_en && (mode != SOC_MODE_EXT);
         OSC_HIGH_CURRENT_OUT <= osc_en && (mode == SOC_MODE_XTAL_HC);
      end
   end

   // interrupt: sticky status, mask, level output
   assign rdy_rise = ready && !rdy_q;

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         rdy_q <= 1'b0;
      end else begin
         rdy_q <= ready;
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         int_status <= 1'b0;
      end else if (!SYS_RESET_N_IN) begin
         int_status <= 1'b0;
      end else if (rdy_rise) begin
         int_status <= 1'b1;
      end else if (wr_fire && PADDR_IN == SOC_INT_CLEAR_ADDR && PWDATA_IN[SOC_RDY_BIT]) begin
         int_status <= 1'b0;
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         int_mask <= 1'b0;
      end else if (!SYS_RESET_N_IN) begin
         int_mask <= 1'b0;
      end else if (wr_fire && PADDR_IN == SOC_INT_ENABLE_ADDR && PWDATA_IN[SOC_RDY_BIT]) begin
         int_mask <= 1'b1;
      end else if (wr_fire && PADDR_IN == SOC_INT_DISABLE_ADDR && PWDATA_IN[SOC_RDY_BIT]) begin
         int_mask <= 1'b0;
      end
   end

   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         IRQ_OUT <= 1'b0;
      end else if (!SYS_RESET_N_IN) begin
         IRQ_OUT <= 1'b0;
      end else begin
         IRQ_OUT <= int_status && int_mask;
      end
   end

   // apb read mux and unmapped decode
   always_comb begin
      next_prdata = SOC_ZERO_WORD;
      next_slverr = 1'b0;
      case (PADDR_IN)
         SOC_CTRL_ADDR: begin
            next_prdata[SOC_EN_BIT] = osc_en;
            next_prdata[SOC_KHZ1_BIT] = khz1_en;
            next_prdata[SOC_KHZ32_BIT] = khz32_en;
            next_prdata[SOC_ALTERNATE_PIN_SELECT_BIT] = pin_alt;
            next_prdata[SOC_MODE_LSB +: SOC_MODE_W] = mode;
            next_prdata[SOC_STARTUP_LSB +: SOC_STARTUP_W] = startup;
         end
         SOC_STATUS_ADDR: begin
            next_prdata[SOC_RDY_BIT] = ready;
         end
         SOC_INT_STATUS_ADDR: begin
            next_prdata[SOC_RDY_BIT] = int_status;
         end
         SOC_INT_MASK_ADDR: begin
            next_prdata[SOC_RDY_BIT] = int_mask;
         end
         SOC_INT_CLEAR_ADDR, SOC_INT_ENABLE_ADDR, SOC_INT_DISABLE_ADDR: begin
            next_prdata = SOC_ZERO_WORD;
         end
         default: begin
            next_slverr = 1'b1;
         end
      endcase
   end

   // one wait state: ready rises in the first access cycle's following edge
   always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         PREADY_OUT <= 1'b0;
         PRDATA_OUT <= SOC_ZERO_WORD;
         PSLVERR_OUT <= 1'b0;
      end else if (!SYS_RESET_N_IN) begin
         PREADY_OUT <= 1'b0;
         PRDATA_OUT <= SOC_ZERO_WORD;
         PSLVERR_OUT <= 1'b0;
      end else begin
         PREADY_OUT <= rd_phase;
         PRDATA_OUT <= (rd_phase && !PWRITE_IN) ? next_prdata : SOC_ZERO_WORD;
         PSLVERR_OUT <= rd_phase && next_slverr;
      end
   end

   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RESET_N_IN);

   a_pins_released: assert property (!osc_en |=> !SLOW_XTAL_IN_OWN_OUT && !ALT_XTAL_IN_OWN_OUT)
      else $error("pins held while oscillator off");
   a_pin_takeover: assert property (osc_en && !pin_alt |=> SLOW_XTAL_IN_OWN_OUT)
      else $error("default pin not taken while enabled");
   a_ext_out_free: assert property (mode == SOC_MODE_EXT |=> !SLOW_XTAL_OUT_OWN_OUT && !ALT_XTAL_OUT_OWN_OUT)
      else $error("output pin held in external clock mode");
   a_mode_drive: assert property (osc_en && mode == SOC_MODE_XTAL_HC |=> OSC_XTAL_MODE_OUT && OSC_HIGH_CURRENT_OUT)
      else $error("high current crystal mode not driven");
   a_no_sleep_gate: assert property (osc_en |=> OSC_ENABLE_OUT)
      else $error("oscillator enable dropped while enabled");
   a_output_masked: assert property (!ready |=> !CLK32K_OUT && !CLK1K_OUT)
      else $error("clock output leaked during start-up");
   a_restart_delay: assert property ($rose(osc_en) |=> state == SOC_STARTING ##1 !ready)
      else $error("start-up skipped after enable");
   a_ready_after_count: assert property (cnt_done && osc_en && state == SOC_STARTING |=> ready)
      else $error("ready not set after start-up count");
   a_irq_set: assert property (rdy_rise && SYS_RESET_N_IN |=> int_status)
      else $error("ready rise not recorded");
   a_irq_level: assert property (int_status && int_mask && SYS_RESET_N_IN |=> IRQ_OUT)
      else $error("enabled interrupt not raised");
   a_mask_set: assert property (wr_fire && PADDR_IN == SOC_INT_ENABLE_ADDR && PWDATA_IN[SOC_RDY_BIT]
      && SYS_RESET_N_IN |=> int_mask)
      else $error("mask bit not set by enable write");
   a_survive_sysrst: assert property (!SYS_RESET_N_IN && !wr_fire |=> $stable(osc_en) && $stable(mode))
      else $error("control changed by system reset");
   a_khz1_gate: assert property (!khz1_en |=> !CLK1K_OUT)
      else $error("1 kHz output while disabled");
   a_khz32_gate: assert property (!khz32_en |=> !CLK32K_OUT)
      else $error("32 kHz output while disabled");
   a_alt_pins: assert property (osc_en && pin_alt |=> ALT_XTAL_IN_OWN_OUT && !SLOW_XTAL_IN_OWN_OUT)
      else $error("alternate pins not selected");

   c_ready: cover property (state == SOC_STARTING ##1 ready);
   c_irq: cover property ($rose(IRQ_OUT));
   c_khz1: cover property ($rose(CLK1K_OUT));
   c_alt_ready: cover property (ready && pin_alt && mode == SOC_MODE_XTAL);
endmodule
`default_nettype wire

// ===== src/soc_pkg.sv
// constants and types shared by the slow oscillator control block
package soc_pkg;
   // register byte offsets
   localparam logic [7:0] SOC_CTRL_ADDR = 8'h00;
   localparam logic [7:0] SOC_STATUS_ADDR = 8'h04;
   localparam logic [7:0] SOC_INT_STATUS_ADDR = 8'h08;
   localparam logic [7:0] SOC_INT_CLEAR_ADDR = 8'h0C;
   localparam logic [7:0] SOC_INT_ENABLE_ADDR = 8'h10;
   localparam logic [7:0] SOC_INT_DISABLE_ADDR = 8'h14;
   localparam logic [7:0] SOC_INT_MASK_ADDR = 8'h18;
   // control register field positions
   localparam int SOC_EN_BIT = 0;
   localparam int SOC_KHZ1_BIT = 1;
   localparam int SOC_KHZ32_BIT = 2;
   localparam int SOC_ALTERNATE_PIN_SELECT_BIT = 3;
   localparam int SOC_MODE_LSB = 8;
   localparam int SOC_MODE_W = 3;
   localparam int SOC_STARTUP_LSB = 16;
   localparam int SOC_STARTUP_W = 4;
   // status and interrupt bit position
   localparam int SOC_RDY_BIT = 0;
   // reset value of the control register (32 kHz output enabled)
   localparam logic [31:0] SOC_CTRL_RESET = 32'h0000_0004;
   localparam logic [31:0] SOC_ZERO_WORD = 32'h0000_0000;
   // mode encodings
   localparam logic [2:0] SOC_MODE_EXT = 3'h0;
   localparam logic [2:0] SOC_MODE_XTAL = 3'h1;
   localparam logic [2:0] SOC_MODE_XTAL_HC = 3'h4;
   localparam logic [2:0] SOC_MODE_RESET = 3'h0;
   localparam logic [3:0] SOC_STARTUP_RESET = 4'h0;
   // start-up counter width and unit step
   localparam int SOC_STARTUP_CNT_W = 16;
   localparam logic [15:0] SOC_STARTUP_ONE = 16'h0001;
   localparam logic [15:0] SOC_STARTUP_CLR = 16'h0000;
   // 1 kHz divider: toggle every 16 oscillator edges (32768 / 32)
   localparam logic [3:0] SOC_KHZ1_LAST = 4'hF;
   localparam logic [3:0] SOC_KHZ1_CLR = 4'h0;
   localparam logic [3:0] SOC_KHZ1_ONE = 4'h1;
   typedef enum logic [2:0] {
      SOC_OFF = 3'b001,
      SOC_STARTING = 3'b010,
      SOC_READY = 3'b100
   } soc_state_e;
endpackage

// ===== src/soc_startup_cnt.sv
// start-up counter that masks the oscillator until its selected length elapses
`timescale 1ns/1ps
`default_nettype none
module soc_startup_cnt (
   input wire logic clk_in, // system clock
   input wire logic rst_n_in, // power-on reset, active low
   input wire logic load_in, // restart the count
   input wire logic edge_in, // one oscillator cycle seen
   input wire logic [soc_pkg::SOC_STARTUP_W-1:0] sel_in, // start-up length select
   output logic done_out // start-up length reached
);
   import soc_pkg::*;
   logic [SOC_STARTUP_CNT_W-1:0] cnt;
   logic [SOC_STARTUP_CNT_W-1:0] last;

   // length is 2**sel oscillator cycles
   assign last = (SOC_STARTUP_ONE << sel_in) - SOC_STARTUP_ONE;

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt <= SOC_STARTUP_CLR;
         done_out <= 1'b0;
      end else if (load_in) begin
         cnt <= SOC_STARTUP_CLR;
         done_out <= 1'b0;
      end else if (edge_in && !done_out) begin
         cnt <= cnt + SOC_STARTUP_ONE;
         if (cnt == last) begin
            done_out <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== sim/soc_xtal_model.sv
// oscillator source model driving one oscillator input pin
`timescale 1ns/1ps
`default_nettype none
module soc_xtal_model #(
   parameter int HALF = 8
) (
   input wire logic clk_in, // system clock
   input wire logic run_in, // pin owned by the clock unit
   output logic pin_out // pin level
);
   int cnt = 0;
   initial pin_out = 1'b0;
   always @(posedge clk_in) begin
      if (run_in) begin
         cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
         if (cnt == HALF - 1) pin_out <= ~pin_out;
      end else begin
         // released pin: no stable level to rely on
         cnt <= 0;
         pin_out <= ~pin_out;
      end
   end
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// testbench for the slow oscillator control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import soc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sys_n = 1'b1;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] rd;
   logic er;
   logic [31:0] prdata;
   logic pready, pslverr, in_own, out_own, ain_own, aout_own;
   logic osc_en, xmode, hc, c32, c1k, irq, pin_d, pin_a, pin_q, c32_q, c1k_q;
   logic sel = 1'b0;
   logic cnt_on = 1'b0;
   int bad_count = 0;
   int n_tests = 0;
   int cycles = 0;
   int edges = 0;
   int base = 0;
   int need = 0;
   int leaks = 0;
   int r32 = 0;
   int r1k = 0;
   always #5 clk = ~clk;
   soc_slow_osc i_soc_slow_osc (.CLK_IN(clk), .RESET_N_IN(rst_n), .SYS_RESET_N_IN(sys_n),
      .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
      .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
      .SLOW_XTAL_IN_IN(pin_d), .ALT_XTAL_IN_IN(pin_a), .SLOW_XTAL_IN_OWN_OUT(in_own),
      .SLOW_XTAL_OUT_OWN_OUT(out_own), .ALT_XTAL_IN_OWN_OUT(ain_own),
      .ALT_XTAL_OUT_OWN_OUT(aout_own), .OSC_ENABLE_OUT(osc_en), .OSC_XTAL_MODE_OUT(xmode),
      .OSC_HIGH_CURRENT_OUT(hc), .CLK32K_OUT(c32), .CLK1K_OUT(c1k), .IRQ_OUT(irq));
   soc_xtal_model #(.HALF(8)) i_soc_xtal_model (.clk_in(clk), .run_in(osc_en & in_own),
      .pin_out(pin_d));
   soc_xtal_model #(.HALF(5)) i_soc_xtal_model_alt (.clk_in(clk), .run_in(osc_en & ain_own),
      .pin_out(pin_a));
   task automatic give_verdict;
      $display("tests %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      pin_q <= sel ? pin_a : pin_d;
      c32_q <= c32;
      c1k_q <= c1k;
      if (cnt_on && !pin_q && (sel ? pin_a : pin_d)) edges <= edges + 1;
      if (cnt_on && edges - base < need && c32) leaks <= leaks + 1;
      if (c32 && !c32_q) r32 <= r32 + 1;
      if (c1k && !c1k_q) r1k <= r1k + 1;
      if (cycles == 60000) begin
         bad_count++;
         give_verdict;
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) bad_count++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic settle;
      repeat (3) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdr(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask
   // fields first with the oscillator off, then the enable bit alone
   task automatic start_up(input logic [31:0] cfg, input int n);
      int k;
      int l0;
      wr(SOC_CTRL_ADDR, cfg);
      sel = cfg[SOC_ALTERNATE_PIN_SELECT_BIT];
      need = n;
      l0 = leaks;
      wr(SOC_CTRL_ADDR, cfg | 32'h0000_0001);
      base = edges;
      cnt_on = 1'b1;
      k = 0;
      do begin
         rdr(SOC_STATUS_ADDR);
         k++;
      end while (rd[SOC_RDY_BIT] !== 1'b1 && k < 100);
      cnt_on = 1'b0;
      chk(rd, 32'h0000_0001);
      chk(32'(edges - base >= n && edges - base <= n + 2), 32'h0000_0001);
      chk(32'(leaks - l0), 32'h0000_0000);
      settle;
   endtask
   task automatic t_reset;
      rdr(SOC_CTRL_ADDR);
      chk(rd, SOC_CTRL_RESET);
      rdr(SOC_STATUS_ADDR);
      chk(rd, SOC_ZERO_WORD);
      chk({in_own, out_own, ain_own, aout_own, osc_en, irq}, 32'h0000_0000);
      rdr(8'h1C);
      chk(er, 1'b1);
   endtask
   task automatic t_crystal;
      wr(SOC_INT_ENABLE_ADDR, 32'h0000_0001);
      rdr(SOC_INT_MASK_ADDR);
      chk(rd, 32'h0000_0001);
      start_up(32'h0002_0106, 4);
      chk({in_own, out_own, ain_own, aout_own}, 32'h0000_000C);
      chk({xmode, hc}, 32'h0000_0002);
      rdr(SOC_INT_STATUS_ADDR);
      chk(rd, 32'h0000_0001);
      settle;
      chk(irq, 1'b1);
      wr(SOC_INT_DISABLE_ADDR, 32'h0000_0001);
      settle;
      chk(irq, 1'b0);
      wr(SOC_INT_ENABLE_ADDR, 32'h0000_0001);
      wr(SOC_INT_CLEAR_ADDR, 32'h0000_0001);
      rdr(SOC_INT_STATUS_ADDR);
      chk(rd, SOC_ZERO_WORD);
      settle;
      chk(irq, 1'b0);
   endtask
   task automatic t_outputs(input logic [31:0] cfg, input logic on);
      int a;
      int b;
      wr(SOC_CTRL_ADDR, cfg);
      settle;
      a = r32;
      b = r1k;
      repeat (700) @(posedge clk);
      #1;
      chk(32'(r32 > a), 32'(on));
      chk(32'(r1k > b), 32'(on));
   endtask
   task automatic t_sys;
      @(posedge clk);
      sys_n <= 1'b0;
      @(posedge clk);
      sys_n <= 1'b1;
      settle;
      chk(osc_en, 1'b1);
      rdr(SOC_CTRL_ADDR);
      chk(rd, 32'h0002_0101);
      rdr(SOC_STATUS_ADDR);
      chk(rd, 32'h0000_0001);
      rdr(SOC_INT_MASK_ADDR);
      chk(rd, SOC_ZERO_WORD);
   endtask
   task automatic t_mode(input logic [2:0] m);
      logic [31:0] cfg;
      cfg = {12'h000, 4'h1, 5'h00, m, 8'h0C};
      // stop the oscillator by clearing the enable bit alone
      rdr(SOC_CTRL_ADDR);
      wr(SOC_CTRL_ADDR, {rd[31:1], 1'b0});
      settle;
      chk({osc_en, in_own, out_own, ain_own, aout_own}, 32'h0000_0000);
      start_up(cfg, 2);
      chk({in_own, out_own, ain_own, aout_own}, {30'h0, 1'b1, m != SOC_MODE_EXT});
      chk({xmode, hc}, {30'h0, m != SOC_MODE_EXT, m == SOC_MODE_XTAL_HC});
      wr(SOC_CTRL_ADDR, {cfg[31:1], 1'b0});
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_crystal;
      t_outputs(32'h0002_0107, 1'b1);
      t_outputs(32'h0002_0101, 1'b0);
      t_sys;
      t_mode(SOC_MODE_EXT);
      t_mode(SOC_MODE_XTAL);
      t_mode(SOC_MODE_XTAL_HC);
      for (int m = 2; m < 8; m++) begin
         if (m != 4) begin
            wr(SOC_CTRL_ADDR, {21'h0, 3'(m), 8'h0C});
            rdr(SOC_CTRL_ADDR);
            chk(rd[10:8], SOC_MODE_XTAL_HC);
         end
      end
      // power-on reset while the oscillator runs must return everything to default
      wr(SOC_CTRL_ADDR, {rd[31:1], 1'b1});
      settle;
      chk(osc_en, 1'b1);
      @(posedge clk);
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      rdr(SOC_CTRL_ADDR);
      chk(rd, SOC_CTRL_RESET);
      chk({in_own, out_own, ain_own, aout_own, osc_en, irq}, 32'h0000_0000);
      give_verdict;
   end
endmodule
`default_nettype wire
